/* File: hdl/mctu_top.sv */
// Four-channel 16-bit timer unit with APB register access.
// Assumes one clock, synchronous reset and asynchronous timer pins.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mctu_top #(
  parameter logic [15:0] LIN_WAKE_MIN = mctu_pkg::LIN_WAKE_MIN_CYC,
  parameter logic [15:0] LIN_BREAK_MIN = mctu_pkg::LIN_BREAK_MIN_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave
  input wire mctu_pkg::mctu_apb_req_s i_apb,
  output var mctu_pkg::mctu_apb_rsp_s o_apb,
  // Timer pins and serial receive line
  input wire logic [3:0] i_tin,
  input wire logic i_rxd,
  output var logic [3:0] o_tout,
  // Channel interrupts, one-cycle pulses
  output var logic [3:0] o_chan_int,
  output var logic [3:0] o_upper_int
);

  localparam int NCH = mctu_pkg::NUM_CH;

  mctu_pkg::mctu_state_s st, nx;
  logic [NCH:0] rise, fall;
  logic [NCH-1:0] edge_ok;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_err;

  // Edge selection decode
  function automatic logic valid_edge(input logic [1:0] esel, input logic r,
                                      input logic f);
    unique case (esel)
      mctu_pkg::EDGE_FALL: return f;
      mctu_pkg::EDGE_RISE: return r;
      default: return r | f;
    endcase
  endfunction

  // Channel register window decode
  function automatic logic is_chan(input logic [7:0] addr);
    return addr[7:6] == 2'b00;
  endfunction

  // Pins and the receive line share one synchroniser bank
  mctu_pin_sync #(
    .W(NCH + 1)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin({i_rxd, i_tin}),
    .o_rise(rise),
    .o_fall(fall)
  );

  // Per-channel valid edge
  for (genvar g = 0; g < NCH; g++) begin : g_edge
    assign edge_ok[g] = valid_edge(st.ch[g].esel, rise[g], fall[g]);
    assign o_tout[g] = st.ch[g].out;
  end

  // Write completes in the access cycle with pready high
  assign wr_en = i_apb.psel & i_apb.penable & st.rsp.pready & i_apb.pwrite;

  // Read mux, sampled in the setup cycle
  always_comb begin
    logic [1:0] c;
    c = i_apb.paddr[5:4];
    rd_data = '0;
    rd_err = 1'b0;
    if (i_apb.paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end else if (is_chan(i_apb.paddr)) begin
      unique case (i_apb.paddr[3:0])
        mctu_pkg::OFS_DATA: rd_data[15:0] = st.ch[c].data;
        mctu_pkg::OFS_MODE: begin
          rd_data[mctu_pkg::MODE_POS +: 4] = st.ch[c].mode;
          rd_data[mctu_pkg::ESEL_POS +: 2] = st.ch[c].esel;
        end
        mctu_pkg::OFS_CAPT: rd_data[15:0] = st.ch[c].capt;
        mctu_pkg::OFS_CNT: rd_data[15:0] = st.ch[c].cnt;
        default: rd_err = 1'b1;
      endcase
    end else if (i_apb.paddr == mctu_pkg::ADDR_START) begin
      rd_data[NCH-1:0] = st.en;
    end else if (i_apb.paddr == mctu_pkg::ADDR_LIN) begin
      rd_data[mctu_pkg::LIN_WAKE_POS] = st.wake;
      rd_data[mctu_pkg::LIN_BRK_POS] = st.brk;
      rd_data[mctu_pkg::LIN_PHASE_POS +: 2] = st.lin;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Next state: bus answer, flag clears, channel engines, config writes
  always_comb begin
    nx = st;
    nx.ints = '0;
    nx.uint = '0;
    nx.rsp.pready = 1'b0;
    nx.rsp.pslverr = 1'b0;
    // Zero wait state: answer is ready for the first access cycle
    if (i_apb.psel && !i_apb.penable) begin
      nx.rsp.pready = 1'b1;
      nx.rsp.prdata = rd_data;
      nx.rsp.pslverr = rd_err;
    end
    // Clears go first so a same-cycle hardware set wins
    if (wr_en && i_apb.paddr == mctu_pkg::ADDR_LIN) begin
      if (i_apb.pwdata[mctu_pkg::LIN_WAKE_POS]) begin
        nx.wake = 1'b0;
      end
      if (i_apb.pwdata[mctu_pkg::LIN_BRK_POS]) begin
        nx.brk = 1'b0;
      end
      if (i_apb.pwdata[mctu_pkg::LIN_RESTART_POS]) begin
        nx.lin = mctu_pkg::LIN_WAKE;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (st.en[i]) begin
        unique case (mctu_pkg::mctu_mode_e'(st.ch[i].mode))
          mctu_pkg::MODE_INTERVAL, mctu_pkg::MODE_SQUARE: begin
            if (st.ch[i].cnt == 16'h0000) begin
              nx.ch[i].cnt = st.ch[i].data;
              nx.ints[i] = 1'b1;
              if (st.ch[i].mode == mctu_pkg::MODE_SQUARE) begin
                nx.ch[i].out = ~st.ch[i].out;
              end
            end else begin
              nx.ch[i].cnt = st.ch[i].cnt - 16'h0001;
            end
          end
          // edge counting, divider on channel 0 only
          mctu_pkg::MODE_EVENT, mctu_pkg::MODE_DIVIDER: begin
            if (edge_ok[i] && (i == 0 || st.ch[i].mode == mctu_pkg::MODE_EVENT)) begin
              if (st.ch[i].cnt == 16'h0000) begin
                nx.ch[i].cnt = st.ch[i].data;
                nx.ints[i] = 1'b1;
                if (st.ch[i].mode == mctu_pkg::MODE_DIVIDER) begin
                  nx.ch[i].out = ~st.ch[i].out;
                end
              end else begin
                nx.ch[i].cnt = st.ch[i].cnt - 16'h0001;
              end
            end
          end
          // capture and restart at each valid edge
          mctu_pkg::MODE_PERIOD: begin
            if (edge_ok[i]) begin
              nx.ch[i].capt = st.ch[i].cnt;
              nx.ch[i].cnt = 16'h0000;
              nx.ints[i] = 1'b1;
            end else begin
              nx.ch[i].cnt = st.ch[i].cnt + 16'h0001;
            end
          end
          // rising select measures high, falling measures low
          mctu_pkg::MODE_WIDTH: begin
            if (st.ch[i].esel == mctu_pkg::EDGE_RISE ? rise[i] : fall[i]) begin
              nx.ch[i].cnt = 16'h0000;
              nx.ch[i].run = 1'b1;
            end else if (st.ch[i].run &&
                         (st.ch[i].esel == mctu_pkg::EDGE_RISE ? fall[i] : rise[i])) begin
              nx.ch[i].capt = st.ch[i].cnt;
              nx.ch[i].run = 1'b0;
              nx.ints[i] = 1'b1;
            end else if (st.ch[i].run) begin
              nx.ch[i].cnt = st.ch[i].cnt + 16'h0001;
            end
          end
          mctu_pkg::MODE_DELAY: begin
            if (!st.ch[i].run) begin
              if (edge_ok[i]) begin
                nx.ch[i].cnt = st.ch[i].data;
                nx.ch[i].run = 1'b1;
              end
            end else if (st.ch[i].cnt == 16'h0000) begin
              nx.ch[i].run = 1'b0;
              nx.ints[i] = 1'b1;
            end else begin
              nx.ch[i].cnt = st.ch[i].cnt - 16'h0001;
            end
          end
          // slaves start on the channel 0 interrupt
          mctu_pkg::MODE_ONESHOT, mctu_pkg::MODE_PWM: begin
            if (i != 0 && st.ints[0]) begin
              nx.ch[i].cnt = st.ch[i].data;
              nx.ch[i].run = st.ch[i].data != 16'h0000;
              nx.ch[i].out = st.ch[i].data != 16'h0000;
            end else if (st.ch[i].run) begin
              if (st.ch[i].cnt == 16'h0001) begin
                nx.ch[i].cnt = 16'h0000;
                nx.ch[i].run = 1'b0;
                nx.ch[i].out = 1'b0;
                nx.ints[i] = 1'b1;
              end else begin
                nx.ch[i].cnt = st.ch[i].cnt - 16'h0001;
              end
            end
          end
          // two byte timers, channels 1 and 3 only
          mctu_pkg::MODE_SPLIT8: begin
            if (i == 1 || i == 3) begin
              if (st.ch[i].cnt[7:0] == 8'h00) begin
                nx.ch[i].cnt[7:0] = st.ch[i].data[7:0];
                nx.ints[i] = 1'b1;
              end else begin
                nx.ch[i].cnt[7:0] = st.ch[i].cnt[7:0] - 8'h01;
              end
              if (st.ch[i].cnt[15:8] == 8'h00) begin
                nx.ch[i].cnt[15:8] = st.ch[i].data[15:8];
                nx.uint[i] = 1'b1;
              end else begin
                nx.ch[i].cnt[15:8] = st.ch[i].cnt[15:8] - 8'h01;
              end
            end
          end
          // LIN receive line measurement
          mctu_pkg::MODE_LIN: begin
            if (st.lin == mctu_pkg::LIN_SYNC && (rise[NCH] || fall[NCH])) begin
              // every sync edge captures the last width
              nx.ch[i].capt = st.ch[i].cnt;
              nx.ch[i].cnt = 16'h0000;
              nx.ch[i].run = 1'b1;
              nx.ints[i] = 1'b1;
            end else if (fall[NCH]) begin
              nx.ch[i].cnt = 16'h0000;
              nx.ch[i].run = 1'b1;
            end else if (rise[NCH] && st.ch[i].run) begin
              nx.ch[i].capt = st.ch[i].cnt;
              nx.ch[i].run = 1'b0;
              nx.ints[i] = 1'b1;
              if (st.lin == mctu_pkg::LIN_WAKE && st.ch[i].cnt >= LIN_WAKE_MIN) begin
                nx.wake = 1'b1;
                nx.lin = mctu_pkg::LIN_BREAK;
              end
              if (st.lin == mctu_pkg::LIN_BREAK && st.ch[i].cnt >= LIN_BREAK_MIN) begin
                nx.brk = 1'b1;
                nx.lin = mctu_pkg::LIN_SYNC;
                nx.ch[i].cnt = 16'h0000;
                nx.ch[i].run = 1'b1;
              end
            end else if (st.ch[i].run && st.ch[i].cnt != 16'hffff) begin
              // Saturate so a stuck-low line never reads short
              nx.ch[i].cnt = st.ch[i].cnt + 16'h0001;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Configuration writes; a fresh start reloads the counter
    if (wr_en && i_apb.paddr[1:0] == 2'b00) begin
      if (is_chan(i_apb.paddr)) begin
        if (i_apb.paddr[3:0] == mctu_pkg::OFS_DATA) begin
          nx.ch[i_apb.paddr[5:4]].data = i_apb.pwdata[15:0];
        end
        if (i_apb.paddr[3:0] == mctu_pkg::OFS_MODE) begin
          nx.ch[i_apb.paddr[5:4]].mode = i_apb.pwdata[mctu_pkg::MODE_POS +: 4];
          nx.ch[i_apb.paddr[5:4]].esel = i_apb.pwdata[mctu_pkg::ESEL_POS +: 2];
        end
      end else if (i_apb.paddr == mctu_pkg::ADDR_START) begin
        nx.en = i_apb.pwdata[NCH-1:0];
        for (int i = 0; i < NCH; i++) begin
          if (i_apb.pwdata[i] && !st.en[i]) begin
            nx.ch[i].cnt = st.ch[i].data;
            nx.ch[i].run = 1'b0;
            nx.ch[i].out = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= mctu_pkg::STATE_RST;
    end else begin
      st <= nx;
    end
  end

  // Outputs straight from state flops
  assign o_chan_int = st.ints;
  assign o_upper_int = st.uint;
  assign o_apb = st.rsp;

  // Checks sit on the channels that the bench drives in each mode
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_reload;
    st.en[0] && st.ch[0].mode == mctu_pkg::MODE_INTERVAL && st.ch[0].cnt == 16'h0000
      |=> o_chan_int[0] && st.ch[0].cnt == $past(st.ch[0].data);
  endproperty
  a_reload: assert property (p_reload) else $error("interval reload missed");

  property p_interval_quiet;
    st.en[0] && st.ch[0].mode == mctu_pkg::MODE_INTERVAL && st.ch[0].cnt != 16'h0000
      |=> !o_chan_int[0];
  endproperty
  a_interval_quiet: assert property (p_interval_quiet) else $error("early interrupt");

  property p_square;
    st.en[1] && st.ch[1].mode == mctu_pkg::MODE_SQUARE && st.ch[1].cnt == 16'h0000
      |=> o_tout[1] != $past(o_tout[1]) && o_chan_int[1];
  endproperty
  a_square: assert property (p_square) else $error("square output not toggled");

  property p_event_hold;
    st.en[2] && st.ch[2].mode == mctu_pkg::MODE_EVENT && !edge_ok[2]
      |=> $stable(st.ch[2].cnt);
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("event count moved");

  property p_divider_ch0;
    st.ch[2].mode == mctu_pkg::MODE_DIVIDER && !wr_en |=> $stable(o_tout[2]);
  endproperty
  a_divider_ch0: assert property (p_divider_ch0) else $error("divider on channel 2");

  property p_period;
    st.en[1] && st.ch[1].mode == mctu_pkg::MODE_PERIOD && edge_ok[1]
      |=> st.ch[1].capt == $past(st.ch[1].cnt) && st.ch[1].cnt == 16'h0000;
  endproperty
  a_period: assert property (p_period) else $error("period capture wrong");

  property p_delay;
    st.en[0] && st.ch[0].mode == mctu_pkg::MODE_DELAY && st.ch[0].run && st.ch[0].cnt == 16'h0000
      |=> o_chan_int[0] && !st.ch[0].run;
  endproperty
  a_delay: assert property (p_delay) else $error("delay expiry missed");

  property p_pwm_start;
    st.en[1] && st.ch[1].mode == mctu_pkg::MODE_PWM && st.ints[0]
      |=> o_tout[1] == ($past(st.ch[1].data) != 16'h0000)
          ##1 st.ch[1].cnt <= $past(st.ch[1].data, 2);
  endproperty
  a_pwm_start: assert property (p_pwm_start) else $error("pwm slave not started");

  property p_split_only;
    1'b1 |-> !o_upper_int[0] && !o_upper_int[2];
  endproperty
  a_split_only: assert property (p_split_only) else $error("split on wrong channel");

  property p_wake;
    st.en[3] && st.ch[3].mode == mctu_pkg::MODE_LIN && st.lin == mctu_pkg::LIN_WAKE &&
      rise[NCH] && st.ch[3].run && st.ch[3].cnt >= LIN_WAKE_MIN
      |=> st.wake && st.lin == mctu_pkg::LIN_BREAK;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up not flagged");

endmodule

`default_nettype wire

/* File: hdl/mctu_pkg.sv */
// Package for the four-channel timer unit: register map, fields, modes,
// reset state and the carrier structs.
// Assumes a single 100 MHz clock and a 32-bit APB register bus.
package mctu_pkg;

  // Unit size
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;

  // Register map: channel n sits at 0x10*n, globals above
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_MODE = 4'h4;
  localparam logic [3:0] OFS_CAPT = 4'h8;
  localparam logic [3:0] OFS_CNT = 4'hc;
  localparam logic [7:0] ADDR_START = 8'h40;
  localparam logic [7:0] ADDR_LIN = 8'h44;

  // Field positions
  localparam int MODE_POS = 0;
  localparam int ESEL_POS = 4;
  localparam int LIN_WAKE_POS = 0;
  localparam int LIN_BRK_POS = 1;
  localparam int LIN_PHASE_POS = 2;
  localparam int LIN_RESTART_POS = 8;

  // LIN thresholds in clock cycles (10 us and 20 us at 100 MHz)
  localparam logic [15:0] LIN_WAKE_MIN_CYC = 16'h03e8;
  localparam logic [15:0] LIN_BREAK_MIN_CYC = 16'h07d0;

  // Edge selection codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [3:0] {
    MODE_IDLE = 4'b0000,
    MODE_INTERVAL = 4'b0001,
    MODE_SQUARE = 4'b0010,
    MODE_EVENT = 4'b0011,
    MODE_DIVIDER = 4'b0100,
    MODE_PERIOD = 4'b0101,
    MODE_WIDTH = 4'b0110,
    MODE_DELAY = 4'b0111,
    MODE_ONESHOT = 4'b1000,
    MODE_PWM = 4'b1001,
    MODE_SPLIT8 = 4'b1010,
    MODE_LIN = 4'b1011
  } mctu_mode_e;

  typedef enum logic [1:0] {
    LIN_WAKE = 2'b00,
    LIN_BREAK = 2'b01,
    LIN_SYNC = 2'b10
  } mctu_lin_e;

  // APB carriers
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } mctu_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mctu_apb_rsp_s;

  // One counting channel
  typedef struct packed {
    logic [CNT_W-1:0] data;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] capt;
    logic [3:0] mode;
    logic [1:0] esel;
    logic run;
    logic out;
  } mctu_chan_s;

  // Whole unit state
  typedef struct packed {
    mctu_chan_s [NUM_CH-1:0] ch;
    logic [NUM_CH-1:0] en;
    logic [NUM_CH-1:0] ints;
    logic [NUM_CH-1:0] uint;
    mctu_lin_e lin;
    logic wake;
    logic brk;
    mctu_apb_rsp_s rsp;
  } mctu_state_s;

  // Everything clears to zero: idle, stopped, outputs low
  localparam mctu_state_s STATE_RST = '0;

endpackage

/* File: hdl/mctu_pin_sync.sv */
// Pin synchroniser and edge detector for the timer input pins.
// Assumes asynchronous pins; a change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module mctu_pin_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Raw pins
  input wire logic [W-1:0] i_pin,
  // Filtered edge pulses
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } mctu_sync_s;

  mctu_sync_s st, nx;
  logic [W-1:0] agree;

  // Stage one feeds only stage two
  assign agree = ~(st.s2 ^ st.s3);

  // Shift chain; level follows only agreeing stages
  always_comb begin
    nx = st;
    nx.s1 = i_pin;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    nx.lvl = (agree & st.s3) | (~agree & st.lvl);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // Edge pulses last one cycle
  assign o_rise = agree & st.s3 & ~st.lvl;
  assign o_fall = agree & ~st.s3 & st.lvl;

endmodule

`default_nettype wire

/* File: verif/mctu_pin_model.sv */
// Pin stimulus model: pulse trains on the timer input pins and receive line.
// Assumes requests come only while idle; every level lasts 3 clocks or more.
`timescale 1ns/1ps
`default_nettype none

module mctu_pin_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Request: sel [3:0] timer inputs, [4] receive line
  input wire logic i_go,
  input wire logic [4:0] i_sel,
  input wire logic [15:0] i_act_len,
  input wire logic [15:0] i_idle_len,
  input wire logic [7:0] i_count,
  // Pins
  output logic [3:0] o_tin,
  output logic o_rxd,
  output logic o_busy
);
  logic [15:0] left;
  logic [15:0] act_len;
  logic [15:0] idle_len;
  logic [7:0] cnt;
  logic [4:0] sel;
  logic act;

  // Active level, then idle level, repeated count times
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      act <= 1'b0;
      sel <= '0;
    end else if (!o_busy && i_go) begin
      o_busy <= 1'b1;
      act <= 1'b1;
      sel <= i_sel;
      left <= i_act_len;
      act_len <= i_act_len;
      idle_len <= i_idle_len;
      cnt <= i_count;
    end else if (o_busy) begin
      if (left > 16'h0001) begin
        left <= left - 16'h0001;
      end else if (act) begin
        act <= 1'b0;
        left <= idle_len;
      end else if (cnt > 8'h01) begin
        cnt <= cnt - 8'h01;
        act <= 1'b1;
        left <= act_len;
      end else begin
        o_busy <= 1'b0;
      end
    end
  end

  // Timer inputs idle low; the receive line idles high, as a pulled-up bus
  assign o_tin = act ? sel[3:0] : 4'h0;
  assign o_rxd = ~(act & sel[4]);
endmodule
`default_nettype wire

/* File: verif/mctu_tb_top.sv */
// Self-checking bench for the four-channel timer unit.
// Assumes the pin model on the timer pins and an APB master in this module.
`timescale 1ns/1ps
`default_nettype none

module mctu_tb_top;
  typedef struct {int ch; int mode; int data; int per;} mctu_row_s;
  localparam logic [7:0] ST = mctu_pkg::ADDR_START;
  localparam logic [7:0] LN = mctu_pkg::ADDR_LIN;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  mctu_pkg::mctu_apb_req_s apb = '0;
  mctu_pkg::mctu_apb_rsp_s rsp;
  logic [3:0] tin, tout, cint, uint_p;
  logic [3:0] ptout = '0;
  logic rxd, busy;
  logic go = 1'b0;
  logic [4:0] sel = '0;
  logic [15:0] act_len = '0;
  logic [15:0] idle_len = '0;
  logic [7:0] pcnt = '0;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0 = 0;
  int ic[4], uc[4], hi[4], tg[4], per[4], last[4];
  mctu_row_s rows [4] = '{'{0, 1, 1, 2}, '{1, 2, 4, 5}, '{2, 1, 7, 8}, '{3, 2, 15, 16}};

  // Clock, 10 ns period
  always #5 i_clk = ~i_clk;

  // Small LIN thresholds keep the run short
  mctu_top #(.LIN_WAKE_MIN(16'h0014), .LIN_BREAK_MIN(16'h0028)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_apb(apb), .o_apb(rsp), .i_tin(tin), .i_rxd(rxd),
    .o_tout(tout), .o_chan_int(cint), .o_upper_int(uint_p));

  mctu_pin_model pins (
    .i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_sel(sel), .i_act_len(act_len),
    .i_idle_len(idle_len), .i_count(pcnt), .o_tin(tin), .o_rxd(rxd), .o_busy(busy));

  // Output monitor on the falling edge, where outputs have settled
  always @(negedge i_clk) begin
    cyc++;
    for (int k = 0; k < 4; k++) begin
      if (cint[k] === 1'b1) begin
        ic[k]++;
        per[k] = cyc - last[k];
        last[k] = cyc;
      end
      if (uint_p[k] === 1'b1) uc[k]++;
      if (tout[k] === 1'b1) hi[k]++;
      if (tout[k] !== ptout[k]) tg[k]++;
    end
    ptout = tout;
  end

  function automatic logic [7:0] ra(input int c, input logic [3:0] o);
    return {2'h0, c[1:0], o};
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer; a spare cycle after it avoids double drives
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic setup(input int c, input logic [31:0] m, input logic [31:0] d);
    bus(ra(c, mctu_pkg::OFS_DATA), 1'b1, d);
    bus(ra(c, mctu_pkg::OFS_MODE), 1'b1, m);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Capture figures may shift by a cycle with synchroniser phase
  task automatic rng(input string nm, input logic [31:0] lo, input logic [31:0] hv,
                     input logic [31:0] g);
    samples_checked++;
    if ((g >= lo && g <= hv) !== 1'b1) begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %0h", nm, lo, hv, g);
    end
  endtask

  task automatic clr();
    for (int k = 0; k < 4; k++) begin
      ic[k] = 0;
      uc[k] = 0;
      hi[k] = 0;
      tg[k] = 0;
    end
  endtask

  // Start a pulse train and wait, bounded, until it is over
  task automatic pulse(input logic [4:0] s, input int a, input int i, input int c);
    int n;
    n = 0;
    sel <= s;
    act_len <= a[15:0];
    idle_len <= i[15:0];
    pcnt <= c[7:0];
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    t0 = cyc;
    do begin
      @(posedge i_clk);
      n++;
    end while (busy !== 1'b0 && n < 2000);
    if (busy !== 1'b0) begin
      error_cnt++;
      summarize();
    end
    repeat (10) @(posedge i_clk);
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge i_clk);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    // Reset state, register width and refused accesses
    chk("tout", 4'h0, tout);
    bus(ra(1, mctu_pkg::OFS_MODE), 1'b0, '0);
    chk("mode", '0, rdat);
    bus(ra(3, mctu_pkg::OFS_DATA), 1'b1, 32'hffffffff);
    bus(ra(3, mctu_pkg::OFS_DATA), 1'b0, '0);
    chk("data16", 32'h0000ffff, rdat);
    bus(8'h48, 1'b0, '0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    // Interval and square rows: period is data plus one
    foreach (rows[r]) begin
      setup(rows[r].ch, rows[r].mode, rows[r].data);
      bus(ST, 1'b1, 32'h1 << rows[r].ch);
      clr();
      repeat (4 * rows[r].per + 8) @(posedge i_clk);
      chk("period", rows[r].per, per[rows[r].ch]);
      chk("toggles", rows[r].mode == 2 ? ic[rows[r].ch] : 0, tg[rows[r].ch]);
    end
    bus(ST, 1'b1, '0);
    // Event count: three rising edges per interrupt
    setup(2, 32'h13, 32'h2);
    bus(ST, 1'b1, 32'h4);
    clr();
    pulse(5'h04, 4, 4, 6);
    chk("events", 2, ic[2]);
    // Pulse interval, then high width
    setup(1, 32'h15, '0);
    setup(3, 32'h16, '0);
    bus(ST, 1'b1, 32'ha);
    pulse(5'h0a, 12, 8, 3);
    bus(ra(1, mctu_pkg::OFS_CAPT), 1'b0, '0);
    rng("interval", 19, 21, rdat);
    bus(ra(3, mctu_pkg::OFS_CAPT), 1'b0, '0);
    rng("width", 11, 13, rdat);
    // Delay of data plus one after the edge
    bus(ST, 1'b1, '0);
    setup(2, 32'h17, 32'ha);
    bus(ST, 1'b1, 32'h4);
    clr();
    pulse(5'h04, 4, 4, 1);
    chk("delay_ints", 1, ic[2]);
    rng("delay", 13, 19, last[2] - t0);
    // Divider only on channel 0; both edges count, so 4 pulses give 8 toggles
    setup(0, 32'h24, '0);
    setup(2, 32'h4, '0);
    bus(ST, 1'b1, 32'h5);
    clr();
    pulse(5'h05, 4, 4, 4);
    chk("div_toggles", 8, tg[0]);
    chk("div_ch2", 0, tg[2]);
    // One-shot: delayed master, slave pulse of data cycles
    bus(ST, 1'b1, '0);
    setup(0, 32'h17, 32'h5);
    setup(1, 32'h8, 32'h4);
    bus(ST, 1'b1, 32'h3);
    clr();
    pulse(5'h01, 4, 4, 1);
    repeat (20) @(posedge i_clk);
    chk("oneshot_high", 4, hi[1]);
    chk("oneshot_ints", 1, ic[1]);
    // Three PWM slaves on a period of ten
    bus(ST, 1'b1, '0);
    setup(0, 32'h1, 32'h9);
    setup(1, 32'h9, 32'h3);
    setup(2, 32'h9, 32'h6);
    setup(3, 32'h9, 32'h1);
    bus(ST, 1'b1, 32'hf);
    repeat (30) @(posedge i_clk);
    clr();
    repeat (100) @(posedge i_clk);
    chk("pwm_period", 10, ic[0]);
    chk("pwm1", 30, hi[1]);
    chk("pwm2", 60, hi[2]);
    chk("pwm3", 10, hi[3]);
    // Split into two 8-bit timers: channel 1 yes, channel 0 no
    bus(ST, 1'b1, '0);
    setup(0, 32'ha, 32'h0302);
    setup(1, 32'ha, 32'h0302);
    bus(ST, 1'b1, 32'h3);
    repeat (20) @(posedge i_clk);
    clr();
    repeat (60) @(posedge i_clk);
    chk("low_byte", 20, ic[1]);
    chk("high_byte", 15, uc[1]);
    chk("split_ch0", 0, ic[0] + uc[0]);
    // LIN: short low, wake, break, then sync widths
    bus(ST, 1'b1, '0);
    setup(3, 32'hb, '0);
    bus(ST, 1'b1, 32'h8);
    pulse(5'h10, 15, 10, 1);
    bus(LN, 1'b0, '0);
    chk("lin_short", 32'h0, rdat);
    pulse(5'h10, 25, 10, 1);
    bus(LN, 1'b0, '0);
    chk("lin_wake", 32'h5, rdat);
    pulse(5'h10, 45, 10, 1);
    bus(LN, 1'b0, '0);
    chk("lin_break", 32'hb, rdat);
    pulse(5'h10, 8, 8, 3);
    bus(ra(3, mctu_pkg::OFS_CAPT), 1'b0, '0);
    rng("lin_sync", 7, 9, rdat);
    bus(LN, 1'b1, 32'h103);
    bus(LN, 1'b0, '0);
    chk("lin_clear", 32'h0, rdat);
    // Mid-run reset while channel 3 holds a capture
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_clk);
    bus(ST, 1'b0, '0);
    chk("rst_start", 32'h0, rdat);
    bus(ra(3, mctu_pkg::OFS_CAPT), 1'b0, '0);
    chk("rst_capt", 32'h0, rdat);
    summarize();
  end
endmodule
`default_nettype wire
